// ===== sleep_pkg.sv
// Shared constants and types of the sleep and power controller
package sleep_pkg;
  localparam logic [1:0] SEL_IDLE     = 2'h0;
  localparam logic [1:0] SEL_ADC_NR   = 2'h1;
  localparam logic [1:0] SEL_PWR_DOWN = 2'h2;
  localparam logic [1:0] SEL_PWR_SAVE = 2'h3;

  localparam int CLK_MHZ          = 50;
  localparam int HALT_CYCLES      = 4;
  localparam int UNLOCK_WINDOW    = 4;
  localparam int NAP_OFF_DELAY    = 3;
  localparam int NAP_OFF_LIFE     = 3;
  localparam int BOD_WAKE_US      = 60;
  localparam int BOD_WAKE_CYCLES  = BOD_WAKE_US * CLK_MHZ;
  localparam int PERIPH_COUNT     = 6;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic async_clk;
    logic main_osc;
    logic timer0_osc;
  } clk_run_t;

  typedef struct packed {
    logic ext_level;
    logic pin_change;
    logic spm_ready;
    logic adc_done;
    logic watchdog_irq;
    logic usi_start;
    logic timer0_irq;
    logic other_io;
  } wake_src_t;
endpackage

// ===== sleep_mode_power_controller.sv
// Sleep-mode entry, clock gating, wake sequencing and brown-out sleep disable
// What this block does
// - Two-bit select: 00 idle, 01 ADC noise, 10 power-down, 11 power-save.
// - Idle stops only CPU and flash clocks; others keep running.
// - In idle any enabled interrupt wakes the core.
// - ADC noise mode halts I/O, CPU, flash clocks; ADC and async run.
// - ADC noise mode wakes only from its listed sources.
// - Power-down stops oscillator and all generated clocks.
// - Power-down wakes only from resets, watchdog, UNIVERSAL_SERIAL_UNIT start, level, pin change.
// - Power-save adds async clock and timer0 wake when async and enabled.
// - Interrupt wake halts core four cycles after start-up, then resumes.
// - Reset during sleep wakes core to the reset vector.
// - Brown-out sleep disable only in power-down/save; re-enables on wake.
// - Wake after brown-out disable stretches by about 60 us.
// - brownout_nap_off one disables detector in sleep; resets to zero.
// - Writes to brownout_nap_off need the timed unlock sequence.
// - Nap-off becomes active three cycles after set, clears three cycles later.
// - Idle or ADC noise entry starts an ADC conversion if ADC enabled.
// - Power-down/save wake waits the fuse-selected clock start-up period.
// - Outside idle, external lines wake only as held level interrupts.
// - Peripheral gate bit stops clock, freezes state, blocks register access.
// - Peripheral gating matters in active and idle only.
`timescale 1ns/1ps
module sleep_mode_power_controller #(
  parameter int STARTUP_CYCLES  = 16384,
  parameter int BOD_WAKE_COUNT  = sleep_pkg::BOD_WAKE_CYCLES,
  parameter int LEVEL_HOLD      = 2,
  parameter int NPER            = sleep_pkg::PERIPH_COUNT
) (
  input  wire logic                  clk_i,               // System clock
  input  wire logic                  rstn_i,              // Async reset, active low
  input  wire logic                  sleep_allow_i,       // Sleep allow bit
  input  wire logic [1:0]            sleep_kind_select_i, // Sleep mode select
  input  wire logic                  sleep_instr_i,       // Sleep instruction executes (pulse)
  input  wire logic                  nap_wr_i,            // Write strobe to the brown-out control bits
  input  wire logic                  nap_wr_off_i,        // Value written to brownout_nap_off
  input  wire logic                  nap_wr_unlock_i,     // Value written to brownout_nap_off_unlock
  input  wire sleep_pkg::wake_src_t  wake_src_i,          // Enabled interrupt requests
  input  wire logic                  ext_level_pin_i,     // External level line, asynchronous
  input  wire logic                  timer0_async_clocking_i, // Timer0 async clocking
  input  wire logic                  global_irq_en_i,     // Global interrupt enable
  input  wire logic                  timer0_irq_mask_i,   // Timer0 overflow/compare enable
  input  wire logic                  sys_reset_req_i,     // External, watchdog or brown-out reset
  input  wire logic                  adc_enabled_i,       // ADC is enabled
  input  wire logic [NPER-1:0]       peripheral_clock_gate_i, // Per-peripheral clock stop
  output logic                       asleep_o,            // Core is in a sleep mode
  output sleep_pkg::clk_run_t        clk_run_o,           // Clock domain enables
  output logic [NPER-1:0]            periph_clk_en_o,     // Per-peripheral clock enables
  output logic [NPER-1:0]            periph_access_en_o,  // Per-peripheral register access
  output logic                       brownout_on_o,       // Brown-out detector enabled
  output logic                       brownout_nap_off_o,  // Nap-off bit as read back
  output logic                       brownout_nap_off_unlock_o, // Unlock bit as read back
  output logic                       adc_start_o,         // Auto-start ADC conversion (pulse)
  output logic                       core_halt_o,         // Core held during wake
  output logic                       irq_resume_o,        // Wake done, run interrupt (pulse)
  output logic                       reset_vector_o       // Restart from reset vector (pulse)
);

  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_SLEEP = 4'h2,
    ST_START = 4'h4,
    ST_HALT  = 4'h8
  } pstate_t;

  localparam int CW = $clog2(STARTUP_CYCLES + BOD_WAKE_COUNT + 2);

  function automatic logic deep_mode(input logic [1:0] sel);
    deep_mode = (sel == sleep_pkg::SEL_PWR_DOWN) || (sel == sleep_pkg::SEL_PWR_SAVE);
  endfunction

  pstate_t            state;
  logic [1:0]         mode;
  logic [CW-1:0]      wait_cnt;
  logic [2:0]         halt_cnt;
  logic               bod_cut;
  logic               unlock;
  logic [2:0]         unlock_cnt;
  logic               nap_off;
  logic [2:0]         nap_age;
  logic               nap_active;
  logic               lvl_s1;
  logic               lvl_s2;
  logic               lvl_s3;
  logic               lvl_req;
  logic [7:0]         lvl_cnt;
  logic               wake;
  logic               enter;

  // Pin level passes three flops; the first is read only by the second
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lvl_s1 <= 1'b0;
      lvl_s2 <= 1'b0;
      lvl_s3 <= 1'b0;
    end else begin
      lvl_s1 <= ext_level_pin_i;
      lvl_s2 <= lvl_s1;
      lvl_s3 <= lvl_s2;
    end
  end

  // Level must stay asserted for LEVEL_HOLD cycles; short glitches never wake
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lvl_cnt <= 8'h00;
      lvl_req <= 1'b0;
    end else if (lvl_s2 && lvl_s3) begin
      if (lvl_cnt < 8'(LEVEL_HOLD))
        lvl_cnt <= lvl_cnt + 8'h01;
      lvl_req <= (lvl_cnt >= 8'(LEVEL_HOLD - 1));
    end else begin
      lvl_cnt <= 8'h00;
      lvl_req <= 1'b0;
    end
  end

  // Wake qualification per mode
  always_comb begin
    case (mode)
      sleep_pkg::SEL_IDLE:
        wake = (|wake_src_i) || lvl_req;
      sleep_pkg::SEL_ADC_NR:
        wake = lvl_req || wake_src_i.pin_change || wake_src_i.spm_ready || wake_src_i.adc_done
             || wake_src_i.watchdog_irq || wake_src_i.usi_start || wake_src_i.timer0_irq;
      sleep_pkg::SEL_PWR_DOWN:
        wake = lvl_req || wake_src_i.pin_change || wake_src_i.watchdog_irq
             || wake_src_i.usi_start;
      default:
        wake = lvl_req || wake_src_i.pin_change || wake_src_i.watchdog_irq || wake_src_i.usi_start
             || (wake_src_i.timer0_irq && timer0_async_clocking_i
                 && timer0_irq_mask_i && global_irq_en_i);
    endcase
  end

  assign enter = (state == ST_RUN) && sleep_instr_i && sleep_allow_i;

  // Sleep/wake sequencer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state    <= ST_RUN;
      mode     <= sleep_pkg::SEL_IDLE;
      wait_cnt <= '0;
      halt_cnt <= 3'h0;
      bod_cut  <= 1'b0;
    end else if (sys_reset_req_i) begin
      state   <= ST_RUN;
      bod_cut <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          if (enter) begin
            state   <= ST_SLEEP;
            mode    <= sleep_kind_select_i;
            bod_cut <= nap_active && deep_mode(sleep_kind_select_i);
          end
        end
        ST_SLEEP: begin
          if (wake) begin
            bod_cut <= 1'b0;
            if (deep_mode(mode)) begin
              state    <= ST_START;
              wait_cnt <= bod_cut ? CW'(STARTUP_CYCLES + BOD_WAKE_COUNT)
                                  : CW'(STARTUP_CYCLES);
            end else begin
              state    <= ST_HALT;
              halt_cnt <= 3'(sleep_pkg::HALT_CYCLES - 1);
            end
          end
        end
        ST_START: begin
          if (wait_cnt <= CW'(1)) begin
            state    <= ST_HALT;
            halt_cnt <= 3'(sleep_pkg::HALT_CYCLES - 1);
          end else begin
            wait_cnt <= wait_cnt - CW'(1);
          end
        end
        ST_HALT: begin
          if (halt_cnt == 3'h0)
            state <= ST_RUN;
          else
            halt_cnt <= halt_cnt - 3'h1;
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // Resume and reset-vector pulses
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_resume_o   <= 1'b0;
      reset_vector_o <= 1'b0;
      adc_start_o    <= 1'b0;
    end else begin
      irq_resume_o   <= !sys_reset_req_i && (state == ST_HALT) && (halt_cnt == 3'h0);
      reset_vector_o <= sys_reset_req_i && (state != ST_RUN);
      adc_start_o    <= enter && adc_enabled_i && !deep_mode(sleep_kind_select_i);
    end
  end

  // Unlock bit lives four cycles; rewriting does not extend it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      unlock     <= 1'b0;
      unlock_cnt <= 3'h0;
    end else if (nap_wr_i && nap_wr_off_i && nap_wr_unlock_i && !unlock) begin
      unlock     <= 1'b1;
      unlock_cnt <= 3'(sleep_pkg::UNLOCK_WINDOW);
    end else if (unlock) begin
      if (unlock_cnt <= 3'h1 || (nap_wr_i && !nap_wr_unlock_i))
        unlock <= 1'b0;
      unlock_cnt <= unlock_cnt - 3'h1;
    end
  end

  // Nap-off: armed by the timed write, active after three cycles, then clears
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nap_off    <= 1'b0;
      nap_age    <= 3'h0;
      nap_active <= 1'b0;
    end else if (unlock && nap_wr_i && nap_wr_off_i && !nap_wr_unlock_i) begin
      nap_off    <= 1'b1;
      nap_age    <= 3'h0;
      nap_active <= 1'b0;
    end else if (nap_off) begin
      nap_age <= nap_age + 3'h1;
      if (nap_age == 3'(sleep_pkg::NAP_OFF_DELAY - 1))
        nap_active <= 1'b1;
      if (nap_age == 3'(sleep_pkg::NAP_OFF_DELAY + sleep_pkg::NAP_OFF_LIFE - 1)) begin
        nap_off    <= 1'b0;
        nap_active <= 1'b0;
      end
    end
  end

  // Clock domain enables per mode
  always_comb begin
    clk_run_o = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1,
                  async_clk: 1'b1, main_osc: 1'b1, timer0_osc: 1'b1};
    if (state == ST_SLEEP) begin
      clk_run_o.cpu   = 1'b0;
      clk_run_o.flash = 1'b0;
      case (mode)
        sleep_pkg::SEL_IDLE: ;
        sleep_pkg::SEL_ADC_NR:
          clk_run_o.io = 1'b0;
        sleep_pkg::SEL_PWR_DOWN: begin
          clk_run_o = '0;
        end
        default: begin
          clk_run_o            = '0;
          clk_run_o.async_clk  = 1'b1;
          clk_run_o.timer0_osc = 1'b1;
        end
      endcase
    end else if (state == ST_START) begin
      clk_run_o = '0;
      clk_run_o.main_osc = 1'b1;
    end
  end

  // Peripheral gating; the io clock already stops them in deeper modes
  assign periph_clk_en_o    = clk_run_o.io ? ~peripheral_clock_gate_i : '0;
  assign periph_access_en_o = ~peripheral_clock_gate_i;

  assign asleep_o                  = (state == ST_SLEEP);
  assign core_halt_o               = (state != ST_RUN);
  assign brownout_on_o             = !(bod_cut && state == ST_SLEEP);
  assign brownout_nap_off_o        = nap_off;
  assign brownout_nap_off_unlock_o = unlock;

  property p_halt_four;
    @(posedge clk_i) disable iff (!rstn_i || sys_reset_req_i)
      ($rose(state == ST_HALT)) |-> ##4 irq_resume_o;
  endproperty
  a_halt_four: assert property (p_halt_four)
    else $error("Interrupt resume not four cycles after halt start");

  property p_enter_needs_allow;
    @(posedge clk_i) disable iff (!rstn_i)
      (state == ST_RUN && sleep_instr_i && !sleep_allow_i && !sys_reset_req_i) |=> state == ST_RUN;
  endproperty
  a_enter_needs_allow: assert property (p_enter_needs_allow)
    else $error("Slept without sleep allow");

  property p_idle_clocks;
    @(posedge clk_i) disable iff (!rstn_i)
      (asleep_o && mode == sleep_pkg::SEL_IDLE) |-> (!clk_run_o.cpu && clk_run_o.io && clk_run_o.adc);
  endproperty
  a_idle_clocks: assert property (p_idle_clocks)
    else $error("Idle clock set wrong");

  property p_adcnr_clocks;
    @(posedge clk_i) disable iff (!rstn_i)
      (asleep_o && mode == sleep_pkg::SEL_ADC_NR) |-> (!clk_run_o.io && clk_run_o.adc);
  endproperty
  a_adcnr_clocks: assert property (p_adcnr_clocks)
    else $error("ADC noise clock set wrong");

  property p_pd_clocks;
    @(posedge clk_i) disable iff (!rstn_i)
      (asleep_o && mode == sleep_pkg::SEL_PWR_DOWN) |-> clk_run_o == '0;
  endproperty
  a_pd_clocks: assert property (p_pd_clocks)
    else $error("Power-down left a clock running");

  property p_reset_wakes;
    @(posedge clk_i) disable iff (!rstn_i)
      (asleep_o && sys_reset_req_i) |=> (reset_vector_o && state == ST_RUN);
  endproperty
  a_reset_wakes: assert property (p_reset_wakes)
    else $error("Reset during sleep did not restart");

  sequence s_nap_write;
    unlock && nap_wr_i && nap_wr_off_i && !nap_wr_unlock_i;
  endsequence
  property p_nap_timing;
    @(posedge clk_i) disable iff (!rstn_i)
      s_nap_write |=> (!nap_active [*3]) ##1 (nap_active [*3]) ##1 !nap_off;
  endproperty
  a_nap_timing: assert property (p_nap_timing)
    else $error("Nap-off active window wrong");

  property p_nap_locked;
    @(posedge clk_i) disable iff (!rstn_i)
      (!unlock && !nap_off) |=> !nap_off;
  endproperty
  a_nap_locked: assert property (p_nap_locked)
    else $error("Nap-off set without unlock");

  property p_bod_back;
    @(posedge clk_i) disable iff (!rstn_i)
      (!asleep_o || !deep_mode(mode)) |-> brownout_on_o;
  endproperty
  a_bod_back: assert property (p_bod_back)
    else $error("Brown-out off outside deep sleep");

  property p_adc_start;
    @(posedge clk_i) disable iff (!rstn_i)
      (enter && adc_enabled_i && sleep_kind_select_i == sleep_pkg::SEL_IDLE && !sys_reset_req_i) |=> adc_start_o;
  endproperty
  a_adc_start: assert property (p_adc_start)
    else $error("No ADC start on idle entry");

endmodule // sleep_mode_power_controller

// ===== test_sleep_mode_power_controller.sv
// Self-checking testbench of the sleep and power controller
`timescale 1ns/1ps
module test_sleep_mode_power_controller;
  localparam int ST = 8;
  localparam int BW = 4;
  localparam int HC = sleep_pkg::HALT_CYCLES;

  logic                 clk_i, rstn_i, sleep_allow_i, sleep_instr_i;
  logic                 nap_wr_i, nap_wr_off_i, nap_wr_unlock_i;
  logic [1:0]           sleep_kind_select_i;
  sleep_pkg::wake_src_t wake_src_i;
  logic                 ext_level_pin_i, timer0_async_clocking_i, global_irq_en_i;
  logic                 timer0_irq_mask_i, sys_reset_req_i, adc_enabled_i;
  logic [5:0]           peripheral_clock_gate_i, periph_clk_en_o, periph_access_en_o;
  sleep_pkg::clk_run_t  clk_run_o;
  logic                 asleep_o, brownout_on_o, brownout_nap_off_o, brownout_nap_off_unlock_o;
  logic                 adc_start_o, core_halt_o, irq_resume_o, reset_vector_o;
  int                   n_mismatch = 0;
  int                   tests_run  = 0;
  // Per mode: clock enables, a source that must wake, a source that must not
  logic [6:0]           ctab [4] = '{7'h1F, 7'h0F, 7'h00, 7'h05};
  logic [7:0]           good [4] = '{8'h01, 8'h10, 8'h40, 8'h02};
  logic [7:0]           bad  [4] = '{8'h00, 8'h01, 8'h10, 8'h20};

  sleep_mode_power_controller #(.STARTUP_CYCLES(ST), .BOD_WAKE_COUNT(BW)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .sleep_allow_i(sleep_allow_i),
    .sleep_kind_select_i(sleep_kind_select_i), .sleep_instr_i(sleep_instr_i),
    .nap_wr_i(nap_wr_i), .nap_wr_off_i(nap_wr_off_i), .nap_wr_unlock_i(nap_wr_unlock_i),
    .wake_src_i(wake_src_i), .ext_level_pin_i(ext_level_pin_i),
    .timer0_async_clocking_i(timer0_async_clocking_i), .global_irq_en_i(global_irq_en_i),
    .timer0_irq_mask_i(timer0_irq_mask_i), .sys_reset_req_i(sys_reset_req_i),
    .adc_enabled_i(adc_enabled_i), .peripheral_clock_gate_i(peripheral_clock_gate_i),
    .asleep_o(asleep_o), .clk_run_o(clk_run_o), .periph_clk_en_o(periph_clk_en_o),
    .periph_access_en_o(periph_access_en_o), .brownout_on_o(brownout_on_o),
    .brownout_nap_off_o(brownout_nap_off_o), .brownout_nap_off_unlock_o(brownout_nap_off_unlock_o),
    .adc_start_o(adc_start_o), .core_halt_o(core_halt_o), .irq_resume_o(irq_resume_o),
    .reset_vector_o(reset_vector_o));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic enter(input logic [1:0] sel, input logic adc_exp);
    @(posedge clk_i);
    sleep_kind_select_i <= sel;
    sleep_instr_i       <= 1'b1;
    @(posedge clk_i);
    sleep_instr_i       <= 1'b0;
    #1;
    check("asleep", asleep_o, 1'b1);
    check("clk_run", clk_run_o, ctab[sel]);
    check("adc_start", adc_start_o, adc_exp);
  endtask

  // A source the mode ignores must leave the core asleep
  task automatic nowake(input logic [7:0] src);
    @(posedge clk_i);
    wake_src_i <= sleep_pkg::wake_src_t'(src);
    repeat (3) @(posedge clk_i);
    wake_src_i <= '0;
    #1;
    check("asleep_held", asleep_o, 1'b1);
  endtask

  // Level wakes go through a synchroniser, so only the resume latency is exact for them
  task automatic wake(input logic [7:0] src, input logic lvl, input int exp_n);
    int n;
    n = 0;
    @(posedge clk_i);
    wake_src_i      <= sleep_pkg::wake_src_t'(src);
    ext_level_pin_i <= lvl;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (asleep_o === 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      end_sim();
    end
    if (!lvl) check("wake_edge", n, 1);
    check("halt", core_halt_o, 1'b1);
    n = 0;
    while (irq_resume_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      wake_src_i      <= '0;
      ext_level_pin_i <= 1'b0;
      #1;
      n++;
    end
    if (n >= 40) begin
      n_mismatch++;
      end_sim();
    end
    check("resume_delay", n, exp_n);
    check("halt_off", core_halt_o, 1'b0);
  endtask

  task automatic nap_write(input logic off, input logic unl);
    @(posedge clk_i);
    nap_wr_i        <= 1'b1;
    nap_wr_off_i    <= off;
    nap_wr_unlock_i <= unl;
    @(posedge clk_i);
    nap_wr_i        <= 1'b0;
    #1;
  endtask

  initial begin
    rstn_i = 1'b0; sleep_allow_i = 1'b0; sleep_instr_i = 1'b0; sleep_kind_select_i = 2'h0;
    nap_wr_i = 1'b0; nap_wr_off_i = 1'b0; nap_wr_unlock_i = 1'b0; wake_src_i = '0;
    ext_level_pin_i = 1'b0; timer0_async_clocking_i = 1'b0; global_irq_en_i = 1'b1;
    timer0_irq_mask_i = 1'b1; sys_reset_req_i = 1'b0; adc_enabled_i = 1'b1;
    peripheral_clock_gate_i = 6'h00;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1;
    check("nap_off_rst", brownout_nap_off_o, 1'b0);
    check("bod_rst", brownout_on_o, 1'b1);
    // Sleep instruction without the allow bit is ignored
    @(posedge clk_i);
    sleep_instr_i <= 1'b1;
    @(posedge clk_i);
    sleep_instr_i <= 1'b0;
    #1;
    check("asleep_refused", asleep_o, 1'b0);
    check("clk_active", clk_run_o, 7'h7F);
    @(posedge clk_i);
    peripheral_clock_gate_i <= 6'h2A;
    sleep_allow_i           <= 1'b1;
    @(posedge clk_i);
    #1;
    check("pclk_active", periph_clk_en_o, 6'h15);
    check("pacc_active", periph_access_en_o, 6'h15);
    for (int m = 0; m < 4; m++) begin
      if (m == 3) begin
        enter(2'(m), 1'b0);
        nowake(8'h02);
        wake(8'h40, 1'b0, ST + HC);
        timer0_async_clocking_i <= 1'b1;
      end
      enter(2'(m), m < 2);
      if (m == 0) check("pclk_idle", periph_clk_en_o, 6'h15);
      if (m > 0) check("pclk_sleep", periph_clk_en_o, 6'h00);
      if (m > 0) nowake(bad[m]);
      wake(good[m], 1'b0, (m < 2) ? HC : ST + HC);
    end
    peripheral_clock_gate_i <= 6'h00;
    // Held level on the external line wakes power-down
    enter(2'h2, 1'b0);
    nowake(8'h80);
    wake(8'h00, 1'b1, ST + HC);
    // Reset request during sleep restarts at the reset vector
    enter(2'h0, 1'b1);
    @(posedge clk_i);
    sys_reset_req_i <= 1'b1;
    @(posedge clk_i);
    sys_reset_req_i <= 1'b0;
    #1;
    check("reset_vector", reset_vector_o, 1'b1);
    check("asleep_reset", asleep_o, 1'b0);
    // Late second write falls outside the unlock window
    nap_write(1'b1, 1'b1);
    check("unlock_set", brownout_nap_off_unlock_o, 1'b1);
    repeat (5) @(posedge clk_i);
    nap_write(1'b1, 1'b0);
    check("nap_off_late", brownout_nap_off_o, 1'b0);
    // Timed sequence then power-down cuts the detector until wake
    nap_write(1'b1, 1'b1);
    nap_write(1'b1, 1'b0);
    check("nap_off_set", brownout_nap_off_o, 1'b1);
    repeat (2) @(posedge clk_i);
    enter(2'h2, 1'b0);
    check("bod_cut", brownout_on_o, 1'b0);
    wake(8'h08, 1'b0, ST + BW + HC);
    check("bod_back", brownout_on_o, 1'b1);
    check("nap_off_clear", brownout_nap_off_o, 1'b0);
    // Idle is not eligible for the detector cut
    nap_write(1'b1, 1'b1);
    nap_write(1'b1, 1'b0);
    repeat (2) @(posedge clk_i);
    enter(2'h0, 1'b1);
    check("bod_idle", brownout_on_o, 1'b1);
    wake(8'h04, 1'b0, HC);
    end_sim();
  end
endmodule // test_sleep_mode_power_controller
